/* core/ccms_core_clock_mode_select.sv */
// Function
// - core clock from bus or fast input
// - selected core clock driven on output pin
// - fully static, clocks may stop indefinitely
// - bus-clocked mode uses bus clock only
// - reset selects bus-clocked mode
// - in sync and async modes, fast clock runs core outside bus accesses
// - buffered writes stay fast, others go bus
// - sync switch costs up to one phase
// - async switch costs up to one cycle
`timescale 1ns/100ps
`default_nettype none

module ccms_core_clock_mode_select (
  // system
  input  wire  logic                  CLK,
  input  wire  logic                  RESET,
  // clock sources, sampled as levels
  input  wire  logic                  BUS_CLOCK_IN,
  input  wire  logic                  FAST_CLOCK_IN,
  // control register mode bits
  input  wire  logic                  NOT_BUS_CLOCKED_BIT,
  input  wire  logic                  ASYNC_SELECT_BIT,
  // external memory access in progress
  input  wire  logic                  ACCESS_ACTIVE,
  input  wire  ccms_pkg::ccms_access_e ACCESS_KIND,
  // core clock
  output logic                        CORE_CLOCK,
  output logic                        CORE_CLOCK_OUT,
  // status
  output logic                        CORE_ON_FAST,
  output logic                        SWITCHING,
  output ccms_pkg::ccms_mode_e        MODE
);
  import ccms_pkg::*;

  typedef enum logic [1:0] {
    CCMS_ST_RUN,
    CCMS_ST_DRAIN,
    CCMS_ST_SYNC
  } ccms_state_e;

  ccms_state_e state_r;
  ccms_state_e state_nxt;
  ccms_mode_e  mode_r;
  ccms_mode_e  mode_nxt;
  logic        src_r;
  logic        target;
  logic        bus_access;
  logic        src_level;
  logic        dst_level;
  logic        dst_prev;
  logic        bus_prev_r;
  logic        fast_prev_r;
  logic        core_r;
  logic        core_nxt;
  logic        dst_ready;

  // mode decode from control bits
  always_comb begin
    if (!NOT_BUS_CLOCKED_BIT) begin
      mode_nxt = CCMS_MODE_BUS;
    end else if (!ASYNC_SELECT_BIT) begin
      mode_nxt = CCMS_MODE_SYNC;
    end else begin
      mode_nxt = CCMS_MODE_ASYNC;
    end
  end

  // mode register, bus-clocked out of reset
  always_ff @(posedge CLK) begin
    if (RESET) begin
      mode_r <= CCMS_MODE_RESET;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // buffered writes never leave the fast clock
  assign bus_access = ACCESS_ACTIVE && (ACCESS_KIND != CCMS_ACC_BUF_WRITE);

  // wanted source
  always_comb begin
    if (mode_r == CCMS_MODE_BUS) begin
      target = CCMS_SRC_BUS;
    end else if (bus_access) begin
      target = CCMS_SRC_BUS;
    end else begin
      target = CCMS_SRC_FAST;
    end
  end

  assign src_level = (src_r == CCMS_SRC_FAST) ? FAST_CLOCK_IN : BUS_CLOCK_IN;
  assign dst_level = (src_r == CCMS_SRC_FAST) ? BUS_CLOCK_IN : FAST_CLOCK_IN;
  assign dst_prev  = (src_r == CCMS_SRC_FAST) ? bus_prev_r : fast_prev_r;

  // sync: wait for the destination low phase, at most one phase
  // async: wait for a falling edge, at most one full cycle,
  // since the unrelated destination phase cannot be trusted
  always_comb begin
    if (mode_r == CCMS_MODE_ASYNC) begin
      dst_ready = dst_prev && !dst_level;
    end else begin
      dst_ready = !dst_level;
    end
  end

  // previous source levels for edge detection
  always_ff @(posedge CLK) begin
    if (RESET) begin
      bus_prev_r  <= CCMS_CLK_RESET;
      fast_prev_r <= CCMS_CLK_RESET;
    end else begin
      bus_prev_r  <= BUS_CLOCK_IN;
      fast_prev_r <= FAST_CLOCK_IN;
    end
  end

  // switch sequencer; no timeout, so stopped clocks simply hold state
  always_comb begin
    state_nxt = state_r;
    core_nxt  = src_level;
    case (state_r)
      CCMS_ST_RUN: begin
        if (target != src_r) begin
          state_nxt = CCMS_ST_DRAIN;
        end
      end
      CCMS_ST_DRAIN: begin
        // only cut the outgoing clock while it is low
        if (!src_level) begin
          state_nxt = CCMS_ST_SYNC;
          core_nxt  = 1'h0;
        end
      end
      CCMS_ST_SYNC: begin
        core_nxt = 1'h0;
        if (target == src_r) begin
          state_nxt = CCMS_ST_RUN;
        end else if (dst_ready) begin
          state_nxt = CCMS_ST_RUN;
        end
      end
      default: begin
        state_nxt = CCMS_ST_RUN;
        core_nxt  = 1'h0;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_r <= CCMS_ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // source select changes only while the output is held low
  always_ff @(posedge CLK) begin
    if (RESET) begin
      src_r <= CCMS_SRC_RESET;
    end else if (state_r == CCMS_ST_SYNC && target != src_r && dst_ready) begin
      src_r <= target;
    end
  end

  // core clock register
  always_ff @(posedge CLK) begin
    if (RESET) begin
      core_r <= CCMS_CLK_RESET;
    end else begin
      core_r <= core_nxt;
    end
  end

  // core clock output, low through a switch
  always_ff @(posedge CLK) begin
    if (RESET) begin
      CORE_CLOCK <= CCMS_CLK_RESET;
    end else begin
      CORE_CLOCK <= core_r;
    end
  end

  // observable copy, same register stage so both stay aligned
  always_ff @(posedge CLK) begin
    if (RESET) begin
      CORE_CLOCK_OUT <= CCMS_CLK_RESET;
    end else begin
      CORE_CLOCK_OUT <= core_r;
    end
  end

  // source status
  always_ff @(posedge CLK) begin
    if (RESET) begin
      CORE_ON_FAST <= CCMS_SRC_RESET;
    end else begin
      CORE_ON_FAST <= src_r;
    end
  end

  // switch in progress
  always_ff @(posedge CLK) begin
    if (RESET) begin
      SWITCHING <= 1'h0;
    end else begin
      SWITCHING <= (state_r != CCMS_ST_RUN);
    end
  end

  // decoded mode
  always_ff @(posedge CLK) begin
    if (RESET) begin
      MODE <= CCMS_MODE_RESET;
    end else begin
      MODE <= mode_r;
    end
  end

endmodule : ccms_core_clock_mode_select

`default_nettype wire

/* core/ccms_pkg.sv */
package ccms_pkg;

  // clock modes
  typedef enum logic [1:0] {
    CCMS_MODE_BUS,
    CCMS_MODE_SYNC,
    CCMS_MODE_ASYNC
  } ccms_mode_e;

  // external memory access kinds
  typedef enum logic [1:0] {
    CCMS_ACC_BUF_WRITE,
    CCMS_ACC_NONBUF_WRITE,
    CCMS_ACC_LINEFILL,
    CCMS_ACC_NC_READ
  } ccms_access_e;

  // source select encoding
  localparam logic       CCMS_SRC_BUS    = 1'h0;
  localparam logic       CCMS_SRC_FAST   = 1'h1;

  // reset values
  localparam ccms_mode_e CCMS_MODE_RESET = CCMS_MODE_BUS;
  localparam logic       CCMS_SRC_RESET  = CCMS_SRC_BUS;
  localparam logic       CCMS_CLK_RESET  = 1'h0;

endpackage : ccms_pkg

/* dv/ccms_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module ccms_asserts (
  // clock, reset, sources, mode bits
  input wire logic                 CLK,
  input wire logic                 RESET,
  input wire logic                 BUS_CLOCK_IN,
  input wire logic                 FAST_CLOCK_IN,
  input wire logic                 NOT_BUS_CLOCKED_BIT,
  input wire logic                 ASYNC_SELECT_BIT,
  // outputs
  input wire logic                 CORE_CLOCK,
  input wire logic                 CORE_CLOCK_OUT,
  input wire logic                 CORE_ON_FAST,
  input wire logic                 SWITCHING,
  input wire ccms_pkg::ccms_mode_e MODE
);
  import ccms_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  clock_copy_a: assert property (CORE_CLOCK_OUT == CORE_CLOCK) else $error("copy");
  reset_bus_a: assert property (disable iff (1'b0) RESET |=> MODE == CCMS_MODE_BUS && !CORE_ON_FAST)
    else $error("reset");
  mode_decode_a: assert property (MODE == ($past(NOT_BUS_CLOCKED_BIT, 2) ?
    ($past(ASYNC_SELECT_BIT, 2) ? CCMS_MODE_ASYNC : CCMS_MODE_SYNC) : CCMS_MODE_BUS)) else $error("decode");
  fast_gate_a: assert property ($rose(CORE_ON_FAST) |-> MODE != CCMS_MODE_BUS) else $error("gate");
  // only judged once the source has been steady long enough to fill the pipe
  clock_follow_a: assert property (!$past(RESET, 3) && !$past(SWITCHING, 3) && !SWITCHING
    && $past(CORE_ON_FAST, 3) == CORE_ON_FAST
    |-> CORE_CLOCK == (CORE_ON_FAST ? $past(FAST_CLOCK_IN, 2) : $past(BUS_CLOCK_IN, 2))) else $error("follow");
  edge_low_a: assert property ($changed(CORE_ON_FAST) |-> !CORE_CLOCK) else $error("glitch");
  sync_cost_a: assert property (MODE == CCMS_MODE_SYNC && $rose(SWITCHING) |-> ##[1:30] !SWITCHING)
    else $error("sync");
  async_cost_a: assert property (MODE == CCMS_MODE_ASYNC && $rose(SWITCHING) |-> ##[1:48] !SWITCHING)
    else $error("async");
endmodule : ccms_asserts
bind ccms_core_clock_mode_select ccms_asserts u_chk (.CLK, .RESET, .BUS_CLOCK_IN, .FAST_CLOCK_IN,
  .NOT_BUS_CLOCKED_BIT, .ASYNC_SELECT_BIT, .CORE_CLOCK, .CORE_CLOCK_OUT, .CORE_ON_FAST, .SWITCHING, .MODE);
`default_nettype wire

/* dv/ccms_clk_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ccms_clk_model (
  // system clock, stop control
  input wire logic clk,
  input wire logic run,
  // generated clocks
  output logic     bus_clk,
  output logic     fast_clk
);
  logic [3:0] cnt_r = 4'h0;
  // holding the count stops both clocks mid-level
  always_ff @(posedge clk) if (run) cnt_r <= cnt_r + 4'h1;
  // fast is four times bus and high at each bus edge
  assign bus_clk  = cnt_r[3];
  assign fast_clk = ~cnt_r[1];
endmodule : ccms_clk_model
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import ccms_pkg::*;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         nbc = 1'b0;
  logic         asel = 1'b0;
  logic         act = 1'b0;
  logic         run = 1'b1;
  ccms_access_e kind = CCMS_ACC_BUF_WRITE;
  logic         bclk, fast_clock_in, core, core_out, fast, sw;
  logic [1:0]   bhist = 2'h0;
  ccms_mode_e   mode;
  int           err_count = 0;
  int           checks = 0;
  always #12.5 clk = ~clk;
  ccms_clk_model u_clk (.clk(clk), .run(run), .bus_clk(bclk), .fast_clk(fast_clock_in));
  // bus level history; core lags the sampled level by two edges
  always @(posedge clk) bhist <= {bhist[0], bclk};
  ccms_core_clock_mode_select DUT (.CLK(clk), .RESET(rst), .BUS_CLOCK_IN(bclk), .FAST_CLOCK_IN(fast_clock_in),
    .NOT_BUS_CLOCKED_BIT(nbc), .ASYNC_SELECT_BIT(asel), .ACCESS_ACTIVE(act), .ACCESS_KIND(kind),
    .CORE_CLOCK(core), .CORE_CLOCK_OUT(core_out), .CORE_ON_FAST(fast), .SWITCHING(sw), .MODE(mode));
  task automatic summarize;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_fast(input logic v);
    int n;
    for (n = 0; fast !== v && n < 80; n++) @(negedge clk);
    if (fast !== v) begin
      err_count++;
      summarize();
    end
  endtask : wait_fast
  task automatic t_reset;
    @(negedge clk);
    chk(4'(mode), 4'(CCMS_MODE_BUS));
    @(posedge clk);
    act  <= 1'b1;
    kind <= CCMS_ACC_LINEFILL;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      chk({2'h0, core_out, core}, {2'h0, bhist[1], bhist[1]});
    end
    chk({3'h0, fast}, 4'h0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_fast(input logic a);
    @(posedge clk);
    act  <= 1'b0;
    nbc  <= 1'b1;
    asel <= a;
    wait_fast(1'b1);
    repeat (3) @(negedge clk);
    chk(4'(mode), 4'(a ? CCMS_MODE_ASYNC : CCMS_MODE_SYNC));
    for (int k = 1; k < 4; k++) begin
      @(posedge clk);
      kind <= ccms_access_e'(k);
      act  <= 1'b1;
      wait_fast(1'b0);
      @(posedge clk);
      act <= 1'b0;
      wait_fast(1'b1);
    end
    @(posedge clk);
    kind <= CCMS_ACC_BUF_WRITE;
    act  <= 1'b1;
    repeat (40) @(negedge clk);
    chk({3'h0, fast}, 4'h1);
    chk({3'h0, sw}, 4'h0);
    $display("t_fast done");
  endtask : t_fast
  task automatic t_stop;
    @(posedge clk);
    run <= 1'b0;
    repeat (50) @(negedge clk);
    chk({3'h0, fast}, 4'h1);
    @(posedge clk);
    run <= 1'b1;
    nbc <= 1'b0;
    wait_fast(1'b0);
    chk(4'(mode), 4'(CCMS_MODE_BUS));
    $display("t_stop done");
  endtask : t_stop
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_fast(1'b0);
    t_fast(1'b1);
    t_stop();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
